// file: hw/core_fetch_and_bank_addressing.sv
`timescale 1ns/1ps
module core_fetch_and_bank_addressing
    import fetch_pkg::*;
#(
    parameter int BANKS_IMPL = 16
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // program memory
    output logic [20:0]      progAddr,
    output logic             progRd,
    input  wire logic [7:0]  progData,
    // data memory
    output dmem_req_t        dmemReq,
    input  wire logic [7:0]  dmemRdata,
    // core status
    output logic [7:0]       bankPtrOut,
    output logic [7:0]       operand,
    output logic             zeroFlag,
    output logic             nopExec,
    output logic [11:0]      literalOut,
    output logic             literalValid,
    output logic             ctrlAreaHit
);
    if (BANKS_IMPL < 1 || BANKS_IMPL > 16) begin : badBanks
        $error("bad bank count");
    end

    logic [1:0]  q_q;
    logic [20:0] pc_q,     pc_d;
    logic [7:0]  fetch_q;
    logic [15:0] ir_q;
    logic        irValid_q;
    two_word_op_t pend_q,  pend_d;
    logic [15:0] first_q;
    logic [3:0]  bank_q;
    logic [7:0]  opnd_q;
    dmem_req_t   req_q,    req_d;
    logic [11:0] lit_q;
    logic        litV_q, nop_q, zero_q, ctrl_q;

    // decode of the executing word
    wire [15:0] w        = ir_q;
    wire        isTagged = w[15:12] == SECOND_WORD_TAG;
    wire        isJump   = w[15:8] == OP_ABS_JUMP;
    wire        isCall   = w[15:9] == OP_ABS_CALL;
    wire        isMove   = w[15:12] == OP_MEM_MOVE;
    wire        isPtr    = w[15:8] == OP_PTR_LOAD && w[7:6] == 2'b00;
    wire        isBankLd = w[15:8] == OP_BANK_LOAD;
    wire        isBranch = w[15:11] == OP_REL_BRANCH;
    wire        isRegOp  = w[15:12] != OP_NOP_HI && !isTagged && !isBranch
                           && !isMove && !isJump && !isCall && !isPtr;
    wire        inSeq    = pend_q != OP_NONE;
    wire        loneTag  = isTagged && !inSeq;
    wire        litTake  = isTagged && inSeq;
    wire        start2   = isJump || isCall || isMove || isPtr;

    // banked or fast-window address for single-word register ops
    wire [11:0] mapAddr;
    wire        mapImpl;
    data_addr_map #(.BANKS_IMPL(BANKS_IMPL)) u_map (
        .accessSel  (w[8]),
        .offset     (w[7:0]),
        .bankPtr    (bank_q),
        .addr       (mapAddr),
        .implemented(mapImpl)
    );

    wire [3:0]  moveBank = w[11:8];
    wire        moveImpl = 32'(moveBank) < BANKS_IMPL || moveBank == FAST_HIGH_BANK;
    wire        tagImpl  = 32'(w[11:8]) < BANKS_IMPL || w[11:8] == FAST_HIGH_BANK;
    wire [20:0] jumpPc   = {w[11:0], first_q[7:0], 1'b0};
    wire [20:0] brOfs    = {{9{w[10]}}, w[10:0], 1'b0};
    wire        exec     = q_q == Q1 && irValid_q;

    always_comb begin
        pc_d   = pc_q + 21'd2;
        pend_d = OP_NONE;
        req_d  = '0;
        if (exec) begin
            if (inSeq && isTagged) begin
                if (pend_q == OP_JUMP || pend_q == OP_CALL) begin
                    pc_d = jumpPc;
                end
                if (pend_q == OP_MOVE) begin
                    req_d.wr    = tagImpl;
                    req_d.addr  = w[11:0];
                    req_d.wdata = opnd_q;
                end
            end else if (start2 && !loneTag) begin
                pend_d = isJump ? OP_JUMP : isCall ? OP_CALL :
                         isMove ? OP_MOVE : OP_PTR;
                req_d.rd   = isMove && moveImpl;
                req_d.addr = w[11:0];
            end else if (isBranch) begin
                pc_d = pc_q + brOfs;
            end else if (isRegOp) begin
                req_d.rd   = mapImpl;
                req_d.addr = mapAddr;
            end
        end
    end

    // quarter counter
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q_q <= Q1;
        end else begin
            q_q <= q_q + 2'd1;
        end
    end

    // pc steps once per instruction, at the decode edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pc_q <= '0;
        end else if (q_q == Q1) begin
            pc_q <= pc_d;
        end
    end

    // even byte first, taken at Q2
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fetch_q <= '0;
        end else if (q_q == Q2) begin
            fetch_q <= progData;
        end
    end

    // odd byte completes the word at Q4
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ir_q      <= '0;
            irValid_q <= 1'b0;
        end else if (q_q == Q4) begin
            ir_q      <= {progData, fetch_q};
            irValid_q <= 1'b1;
        end
    end

    // two-word sequencing
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_q  <= OP_NONE;
            first_q <= '0;
        end else if (exec) begin
            pend_q  <= pend_d;
            first_q <= w;
        end
    end

    // data request of the executing word
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_q  <= '0;
            ctrl_q <= 1'b0;
        end else if (exec) begin
            req_q  <= req_d;
            ctrl_q <= req_d.addr >= CTRL_AREA_LO;
        end else if (q_q == Q4) begin
            req_q  <= '0;
        end
    end

    // literal of an in-sequence second word
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lit_q  <= '0;
            litV_q <= 1'b0;
        end else begin
            litV_q <= exec && litTake;
            if (exec && litTake) begin
                lit_q <= w[11:0];
            end
        end
    end

    // lone second word runs as a nop
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nop_q <= 1'b0;
        end else begin
            nop_q <= exec && loneTag;
        end
    end

    // bank pointer, low nibble only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bank_q <= BANK_PTR_RESET[3:0];
        end else if (exec && isBankLd && !inSeq) begin
            bank_q <= w[3:0];
        end
    end

    // operand taken in Q2, zero when refused
    wire [7:0] rdByte = req_q.rd ? dmemRdata : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            opnd_q <= '0;
            zero_q <= 1'b0;
        end else if (q_q == Q2) begin
            opnd_q <= rdByte;
            zero_q <= rdByte == 8'h00;
        end
    end

    // fetch strobe over the even-byte quarters
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            progRd <= 1'b0;
        end else begin
            progRd <= q_q == Q4 || q_q == Q1;
        end
    end

    // even byte address until Q2, then the odd byte
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            progAddr <= '0;
        end else if (q_q == Q4) begin
            progAddr <= pc_q;
        end else if (q_q == Q2) begin
            progAddr <= {progAddr[20:1], 1'b1};
        end
    end

    // data bus: read strobe in Q2, write only in Q4
    wire        rdStrobe = exec && req_d.rd;
    wire [11:0] busAddr  = exec ? req_d.addr : req_q.addr;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dmemReq <= '0;
        end else begin
            dmemReq.addr  <= busAddr;
            dmemReq.wdata <= req_q.wdata;
            dmemReq.rd    <= rdStrobe;
            dmemReq.wr    <= req_q.wr && q_q == Q3;
        end
    end

    // status outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bankPtrOut  <= BANK_PTR_RESET;
            operand     <= '0;
            zeroFlag    <= 1'b0;
            ctrlAreaHit <= 1'b0;
        end else begin
            bankPtrOut  <= {4'h0, bank_q};
            operand     <= opnd_q;
            zeroFlag    <= zero_q;
            ctrlAreaHit <= ctrl_q;
        end
    end

    // pulse outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nopExec      <= 1'b0;
            literalOut   <= '0;
            literalValid <= 1'b0;
        end else begin
            nopExec      <= nop_q;
            literalOut   <= lit_q;
            literalValid <= litV_q;
        end
    end
endmodule

// file: hw/fetch_pkg.sv
package fetch_pkg;

    // program and data address widths
    localparam int PC_W          = 21;
    localparam int DADDR_W       = 12;
    localparam int BANK_W        = 4;
    localparam int OFS_W         = 8;
    localparam int LIT_W         = 12;

    // bank pointer register
    localparam logic [11:0] BANK_PTR_ADDR  = 12'he0e;
    localparam logic [7:0]  BANK_PTR_RESET = 8'h00;

    // fast window split and target banks
    localparam logic [7:0]  FAST_SPLIT     = 8'h60;
    localparam logic [3:0]  FAST_LOW_BANK  = 4'h0;
    localparam logic [3:0]  FAST_HIGH_BANK = 4'hf;

    // control register area in bank 15
    localparam logic [11:0] CTRL_AREA_LO   = 12'hf60;

    // opcode fields
    localparam logic [3:0]  SECOND_WORD_TAG = 4'hf;
    localparam logic [7:0]  OP_ABS_JUMP     = 8'hef;
    localparam logic [6:0]  OP_ABS_CALL     = 7'h76;
    localparam logic [3:0]  OP_MEM_MOVE     = 4'hc;
    localparam logic [7:0]  OP_PTR_LOAD     = 8'hee;
    localparam logic [7:0]  OP_BANK_LOAD    = 8'h01;
    localparam logic [4:0]  OP_REL_BRANCH   = 5'h1a;
    localparam logic [3:0]  OP_NOP_HI       = 4'h0;

    // quarter cycles
    localparam logic [1:0]  Q1 = 2'd0;
    localparam logic [1:0]  Q2 = 2'd1;
    localparam logic [1:0]  Q3 = 2'd2;
    localparam logic [1:0]  Q4 = 2'd3;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_JUMP,
        OP_CALL,
        OP_MOVE,
        OP_PTR
    } two_word_op_t;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [11:0]       addr;
        logic [7:0]        wdata;
    } dmem_req_t;

endpackage

// file: hw/data_addr_map.sv
`timescale 1ns/1ps
module data_addr_map
    import fetch_pkg::*;
#(
    parameter int BANKS_IMPL = 16
) (
    // operand
    input  wire logic       accessSel,
    input  wire logic [7:0] offset,
    input  wire logic [3:0] bankPtr,
    // result
    output logic [11:0]     addr,
    output logic            implemented
);
    if (BANKS_IMPL < 1 || BANKS_IMPL > 16) begin : badBanks
        $error("bad bank count");
    end

    wire        lowHalf  = offset < FAST_SPLIT;
    wire [3:0]  fastBank = lowHalf ? FAST_LOW_BANK : FAST_HIGH_BANK;
    wire [3:0]  bank     = accessSel ? bankPtr : fastBank;

    assign addr = {bank, offset};
    assign implemented = (32'(bank) < BANKS_IMPL) || (bank == FAST_HIGH_BANK);
endmodule

// file: tb/fetch_chk.sv
`timescale 1ns/1ps
module fetch_chk
    import fetch_pkg::*;
#(
    parameter int BANKS_IMPL = 16
) (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // program side
    input wire logic [20:0] progAddr,
    input wire logic        progRd,
    input wire logic [7:0]  progData,
    // data side
    input wire dmem_req_t   dmemReq,
    input wire logic [7:0]  dmemRdata,
    // status
    input wire logic [7:0]  bankPtrOut,
    input wire logic [7:0]  operand,
    input wire logic        zeroFlag,
    input wire logic        nopExec,
    input wire logic [11:0] literalOut,
    input wire logic        literalValid,
    input wire logic        ctrlAreaHit
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire       anyAcc   = dmemReq.rd || dmemReq.wr;
    wire [3:0] bankSel  = dmemReq.addr[11:8];
    wire       implBank = (bankSel < BANKS_IMPL) || (bankSel == 4'hf);
    sequence quietRead;
        !dmemReq.rd [*3];
    endsequence
    sequence ctrlAcc;
        anyAcc && dmemReq.addr >= CTRL_AREA_LO;
    endsequence
    sequence lowAcc;
        anyAcc && dmemReq.addr < CTRL_AREA_LO;
    endsequence
    chk_read_spacing: assert property (dmemReq.rd |=> quietRead)
        else $error("data reads closer than one instruction");
    chk_rd_wr_apart: assert property (!(dmemReq.rd && dmemReq.wr))
        else $error("read and write strobes together");
    chk_write_pulse: assert property (dmemReq.wr |=> !dmemReq.wr)
        else $error("write strobe longer than one cycle");
    chk_bank_refused: assert property (anyAcc |-> implBank)
        else $error("access to an unimplemented bank");
    chk_ptr_upper_zero: assert property (bankPtrOut[7:4] == 4'h0)
        else $error("bank pointer upper nibble not zero");
    chk_zero_tracks: assert property ($changed(operand) |-> zeroFlag == (operand == 8'h00))
        else $error("zero flag disagrees with operand");
    chk_ctrl_area: assert property (ctrlAcc |-> ##[0:2] ctrlAreaHit)
        else $error("control area access not flagged");
    chk_ctrl_clear: assert property (lowAcc |-> ##[0:2] !ctrlAreaHit)
        else $error("storage access flagged as control area");
    chk_literal_pulse: assert property (literalValid |=> !literalValid)
        else $error("literal valid longer than one cycle");
    chk_nop_pulse: assert property (nopExec |=> !nopExec)
        else $error("nop pulse longer than one cycle");
    chk_fetch_even: assert property (progRd |-> !progAddr[0])
        else $error("fetch from an odd byte address");
endmodule

bind core_fetch_and_bank_addressing fetch_chk #(.BANKS_IMPL(BANKS_IMPL)) chk (
    .ref_clk(ref_clk), .rst(rst), .progAddr(progAddr), .progRd(progRd),
    .progData(progData), .dmemReq(dmemReq), .dmemRdata(dmemRdata),
    .bankPtrOut(bankPtrOut), .operand(operand), .zeroFlag(zeroFlag),
    .nopExec(nopExec), .literalOut(literalOut), .literalValid(literalValid),
    .ctrlAreaHit(ctrlAreaHit)
);

// file: tb/fetch_mem_model.sv
`timescale 1ns/1ps
module fetch_mem_model
    import fetch_pkg::*;
(
    // core side
    input  wire logic        ref_clk,
    input  wire logic [20:0] progAddr,
    input  wire dmem_req_t   dmemReq,
    output logic [7:0]       progData,
    output logic [7:0]       dmemRdata
);
    logic [7:0] prog [0:255];
    logic [7:0] ram  [0:4095];
    logic [7:0] lastQ;
    initial begin
        for (int i = 0; i < 4096; i++) begin
            ram[i] = i[7:0] ^ 8'h5a;
            if (i < 256) prog[i] = 8'h00;
        end
        lastQ = 8'h00;
    end
    // byte wide program store
    assign progData  = prog[progAddr[7:0]];
    // released data bus toggles, never holds
    assign dmemRdata = dmemReq.rd ? ram[dmemReq.addr] : ~lastQ;
    always @(posedge ref_clk) begin
        lastQ <= dmemReq.rd ? ram[dmemReq.addr] : ~lastQ;
        if (dmemReq.wr) ram[dmemReq.addr] <= dmemReq.wdata;
    end
endmodule

// file: tb/core_fetch_and_bank_addressing_test.sv
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module core_fetch_and_bank_addressing_test;
    import fetch_pkg::*;
    localparam int BANKS = 4;
    localparam int NRAND = 20;
    logic        ref_clk;
    logic        rst;
    logic [20:0] progAddr;
    logic        progRd;
    logic [7:0]  progData;
    dmem_req_t   dmemReq;
    logic [7:0]  dmemRdata;
    logic [7:0]  bankPtrOut;
    logic [7:0]  operand;
    logic        zeroFlag;
    logic        nopExec;
    logic [11:0] literalOut;
    logic        literalValid;
    logic        ctrlAreaHit;
    int          fail_count;
    int          n_compared;
    int          nopCnt;
    int          seed;
    logic [31:0] r;
    logic [3:0]  bp;
    logic [11:0] ad;
    logic        seenJump;
    logic [11:0] expR[$];
    logic [11:0] gotR[$];
    logic [19:0] gotW[$];
    logic [11:0] gotL[$];
    core_fetch_and_bank_addressing #(.BANKS_IMPL(BANKS)) dut (
        .ref_clk(ref_clk), .rst(rst), .progAddr(progAddr), .progRd(progRd),
        .progData(progData), .dmemReq(dmemReq), .dmemRdata(dmemRdata),
        .bankPtrOut(bankPtrOut), .operand(operand), .zeroFlag(zeroFlag),
        .nopExec(nopExec), .literalOut(literalOut), .literalValid(literalValid),
        .ctrlAreaHit(ctrlAreaHit));
    fetch_mem_model mem (.ref_clk(ref_clk), .progAddr(progAddr), .dmemReq(dmemReq),
        .progData(progData), .dmemRdata(dmemRdata));
    function automatic logic [11:0] map_addr(input logic a, input logic [7:0] ofs,
                                             input logic [3:0] bank);
        if (a) return {bank, ofs};
        return (ofs < FAST_SPLIT) ? {FAST_LOW_BANK, ofs} : {FAST_HIGH_BANK, ofs};
    endfunction
    function automatic bit impl(input logic [11:0] a);
        return a[11:8] < BANKS || a[11:8] == 4'hf;
    endfunction
    task automatic put(input int idx, input logic [15:0] w);
        mem.prog[2*idx]   = w[7:0];
        mem.prog[2*idx+1] = w[15:8];
    endtask
    task automatic end_of_test;
        if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // monitor of strobes and pulses
    always @(posedge ref_clk) if (!rst) begin
        if (dmemReq.rd) gotR.push_back(dmemReq.addr);
        if (dmemReq.wr) gotW.push_back({dmemReq.addr, dmemReq.wdata});
        if (literalValid) gotL.push_back(literalOut);
        if (nopExec) nopCnt++;
        if (progAddr == 21'h80) seenJump = 1'b1;
    end
    initial begin
        int k;
        rst = 1'b1;
        seed = 32'h647899da;
        fail_count = 0;
        n_compared = 0;
        nopCnt = 0;
        seenJump = 1'b0;
        bp = 4'h0;
        #1;
        for (int i = 0; i < NRAND; i++) begin
            r = $random(seed);
            if (r[1:0] == 2'b00) begin
                put(i, {OP_BANK_LOAD, r[15:8]});
                bp = r[11:8];
            end else begin
                put(i, {7'h28, r[2], r[15:8]});
                ad = map_addr(r[2], r[15:8], bp);
                if (impl(ad)) expR.push_back(ad);
            end
        end
        put(NRAND, {OP_BANK_LOAD, 8'hf9});
        put(NRAND + 1, {OP_MEM_MOVE, 12'h123});
        put(NRAND + 2, {SECOND_WORD_TAG, 12'h3a5});
        put(NRAND + 3, {SECOND_WORD_TAG, 12'h0ab});
        put(NRAND + 4, {OP_PTR_LOAD, 8'h00});
        put(NRAND + 5, {SECOND_WORD_TAG, 12'h0cc});
        put(NRAND + 6, {OP_ABS_JUMP, 8'h40});
        put(NRAND + 7, {SECOND_WORD_TAG, 12'h000});
        put(8'h40, {OP_REL_BRANCH, 11'd4});
        put(8'h45, {7'h28, 1'b0, 8'hf9});
        put(8'h46, {7'h28, 1'b1, 8'h10});
        expR.push_back(12'h123);
        expR.push_back(12'hff9);
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        for (k = 0; k < 3000 && progAddr !== 21'h8c; k++) @(negedge ref_clk);
        if (k == 3000) begin
            fail_count++;
            end_of_test();
        end
        repeat (40) @(negedge ref_clk);
        `CHECK("jump target", 1'b1, seenJump)
        `CHECK("read count", expR.size(), gotR.size())
        for (int i = 0; i < expR.size() && i < gotR.size(); i++)
            `CHECK("read address", expR[i], gotR[i])
        `CHECK("write count", 1, gotW.size())
        if (gotW.size() > 0) `CHECK("move write", {12'h3a5, 8'h79}, gotW[0])
        `CHECK("literal count", 3, gotL.size())
        if (gotL.size() == 3) begin
            `CHECK("move literal", 12'h3a5, gotL[0])
            `CHECK("pointer literal", 12'h0cc, gotL[1])
            `CHECK("jump literal", 12'h000, gotL[2])
        end
        `CHECK("lone nop", 1, nopCnt)
        `CHECK("bank pointer", 8'h09, bankPtrOut)
        `CHECK("operand", 8'h00, operand)
        `CHECK("zero flag", 1'b1, zeroFlag)
        end_of_test();
    end
endmodule
